// [core/frwls_consts.vh]
`ifndef FRWLS_CONSTS_VH
`define FRWLS_CONSTS_VH
// Register word addresses (Avalon word index)
`define FRWLS_ADDR_DATA_LOW 3'h0
`define FRWLS_ADDR_DATA_HIGH 3'h1
`define FRWLS_ADDR_ADDR_LOW 3'h2
`define FRWLS_ADDR_ADDR_HIGH 3'h3
`define FRWLS_ADDR_CONTROL 3'h4
`define FRWLS_ADDR_KEY 3'h5
`define FRWLS_ADDR_STATUS 3'h6
// Control bit positions
`define FRWLS_BIT_START 1
`define FRWLS_BIT_ENABLE 2
`define FRWLS_BIT_ERASE 4
`define FRWLS_BIT_LATCH_ONLY 5
`define FRWLS_BIT_CFG 6
`define FRWLS_BIT_ERROR 3
// Values
`define FRWLS_KEY_FIRST 8'h55
`define FRWLS_KEY_SECOND 8'hAA
`define FRWLS_BLANK 14'h3FFF
`define FRWLS_LATCHES 32
`define FRWLS_NOP_CYCLES 2
`define FRWLS_CLK_HZ 100000000
`define FRWLS_PROG_TIME_US 2000
`define FRWLS_PROG_CYCLES ((`FRWLS_PROG_TIME_US) * (`FRWLS_CLK_HZ / 1000000))
`endif

// [core/frwls_latch_bank.v]
`timescale 1ns/1ps
`default_nettype none
`include "frwls_consts.vh"
module frwls_latch_bank (
  input wire clk,
  input wire rstN,
  input wire loadEn,
  input wire [4:0] loadIdx,
  input wire [13:0] loadData,
  input wire blankAll,
  input wire [4:0] readIdx,
  output wire [13:0] readData
);
  reg [13:0] latchQ [0:31];
  integer i;
  // Blank wins over load: a commit or erase ends with every latch blank
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (i = 0; i < `FRWLS_LATCHES; i = i + 1) begin
        latchQ[i] <= `FRWLS_BLANK;
      end
    end else if (blankAll) begin
      for (i = 0; i < `FRWLS_LATCHES; i = i + 1) begin
        latchQ[i] <= `FRWLS_BLANK;
      end
    end else if (loadEn) begin
      latchQ[loadIdx] <= loadData;
    end
  end
  assign readData = latchQ[readIdx];
endmodule
`default_nettype wire

// [core/frwls_sequencer.v]
// What this block does
// - Programming start performs no automatic erase
// - Erase acts only on whole rows
// - One commit writes up to 32 latched words
// - Upper ten address bits row, low five latch
// - Commit targets only the selected row
// - Latches return blank after programming completes
// - Latches blank after erase; unloaded stay blank
// - Load or program only after uninterrupted unlock
// - Load copies 14-bit data pair into latch
// - Latch-only mode loads latch, no programming
// - Otherwise load latch then commit whole row
// - Commit: forced nops, stall, resume third instruction
// - Latch-only load: two forced nops, no stall
// - Erase or program stalls about 2 ms
// - Latches are 14 bits, reached via data
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "frwls_consts.vh"
module frwls_sequencer #(
  parameter PROG_CYCLES = `FRWLS_PROG_CYCLES
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  output reg cpuForceNop,
  output reg cpuStall,
  output reg flashProgram,
  output reg flashErase,
  output reg [9:0] flashRow,
  output reg [4:0] flashWordIdx,
  output reg [13:0] flashWordData
);
  // ****************************************
  // Reset release
  // ****************************************
  reg rstMeta, rstSync;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_NOP = 5'h02;
  localparam [4:0] ST_PROG = 5'h04;
  localparam [4:0] ST_ERASE = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  reg [4:0] stateQ, stateD;
  reg [7:0] dataLowQ, dataHighQ, addrLowQ, addrHighQ;
  reg cfgQ, latchOnlyQ, eraseQ, errQ, enableQ, startQ;
  reg [1:0] keyStepQ;
  reg pendCommitQ, pendEraseQ;
  reg [1:0] nopCntQ;
  reg [31:0] waitCntQ;
  reg [4:0] dumpIdxQ;
  reg latchLoad, blankAll;
  wire [13:0] latchOut;
  wire [13:0] dataWord = {dataHighQ[5:0], dataLowQ};

  function [31:0] frwls_byte;
    input [7:0] b;
    begin
      frwls_byte = {24'h000000, b};
    end
  endfunction

  // ****************************************
  // Latch bank
  // ****************************************
  frwls_latch_bank uLatch (
    .clk(ref_clk),
    .rstN(rstSync),
    .loadEn(latchLoad),
    .loadIdx(addrLowQ[4:0]),
    .loadData(dataWord),
    .blankAll(blankAll),
    .readIdx(dumpIdxQ),
    .readData(latchOut)
  );

  // ****************************************
  // Bus access and unlock
  // ****************************************
  wire busWr = avsWrite && !avsWaitRequest;
  wire busRd = avsRead && !avsWaitRequest;
  wire ctrlWr = busWr && (avsAddress == `FRWLS_ADDR_CONTROL);
  wire keyWr = busWr && (avsAddress == `FRWLS_ADDR_KEY);
  wire startReq = ctrlWr && avsWriteData[`FRWLS_BIT_START] && !startQ;
  wire unlocked = (keyStepQ == 2'd2);
  wire accept = startReq && unlocked && avsWriteData[`FRWLS_BIT_ENABLE] && enableQ;
  wire busy = (stateQ != ST_IDLE);

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    latchLoad = 1'b0;
    blankAll = 1'b0;
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: begin
        if (accept && !cfgQ) begin
          stateD = ST_NOP;
          latchLoad = !avsWriteData[`FRWLS_BIT_ERASE];
        end
      end
      ST_NOP: begin
        if (nopCntQ == 2'd1) begin
          if (pendEraseQ) begin
            stateD = ST_ERASE;
          end else if (pendCommitQ) begin
            stateD = ST_PROG;
          end else begin
            stateD = ST_DONE;
          end
        end
      end
      ST_PROG: begin
        if (waitCntQ == 32'd0) begin
          stateD = ST_DONE;
          blankAll = 1'b1;
        end
      end
      ST_ERASE: begin
        if (waitCntQ == 32'd0) begin
          stateD = ST_DONE;
          blankAll = 1'b1;
        end
      end
      ST_DONE: begin
        stateD = ST_IDLE;
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Wait state
  // ****************************************
  // One wait state per access; requests taken when waitrequest low
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      avsWaitRequest <= 1'b1;
    end else begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
    end
  end

  // ****************************************
  // Unlock chain
  // ****************************************
  // Any other access breaks the chain
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      keyStepQ <= 2'd0;
    end else if (keyWr && avsWriteData[7:0] == `FRWLS_KEY_FIRST) begin
      keyStepQ <= 2'd1;
    end else if (keyWr && keyStepQ == 2'd1 && avsWriteData[7:0] == `FRWLS_KEY_SECOND) begin
      keyStepQ <= 2'd2;
    end else if (busWr || busRd) begin
      keyStepQ <= 2'd0;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Loaded in the wait state so it stands at the taking edge;
  // status may therefore lag the state by one cycle
  wire rdSeen = avsRead && avsWaitRequest;
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      avsReadData <= 32'h00000000;
    end else if (rdSeen) begin
      case (avsAddress)
        `FRWLS_ADDR_DATA_LOW: avsReadData <= frwls_byte(dataLowQ);
        `FRWLS_ADDR_DATA_HIGH: avsReadData <= frwls_byte(dataHighQ);
        `FRWLS_ADDR_ADDR_LOW: avsReadData <= frwls_byte(addrLowQ);
        `FRWLS_ADDR_ADDR_HIGH: avsReadData <= frwls_byte({1'b1, addrHighQ[6:0]});
        `FRWLS_ADDR_CONTROL: avsReadData <= frwls_byte({1'b1, cfgQ, latchOnlyQ,
          eraseQ, errQ, enableQ, startQ, 1'b0});
        `FRWLS_ADDR_STATUS: avsReadData <= frwls_byte({3'b000, stateQ});
        default: avsReadData <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  always @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      stateQ <= ST_IDLE;
      dataLowQ <= 8'h00;
      dataHighQ <= 8'h00;
      addrLowQ <= 8'h00;
      addrHighQ <= 8'h00;
      cfgQ <= 1'b0;
      latchOnlyQ <= 1'b0;
      eraseQ <= 1'b0;
      errQ <= 1'b0;
      enableQ <= 1'b0;
      startQ <= 1'b0;
      pendCommitQ <= 1'b0;
      pendEraseQ <= 1'b0;
      nopCntQ <= 2'd0;
      waitCntQ <= 32'h00000000;
      dumpIdxQ <= 5'h00;
      cpuForceNop <= 1'b0;
      cpuStall <= 1'b0;
      flashProgram <= 1'b0;
      flashErase <= 1'b0;
      flashRow <= 10'h000;
      flashWordIdx <= 5'h00;
      flashWordData <= 14'h0000;
    end else begin
      stateQ <= stateD;
      // ****************************************
      // Register writes, refused while busy
      // ****************************************
      if (busWr && !busy) begin
        case (avsAddress)
          `FRWLS_ADDR_DATA_LOW: dataLowQ <= avsWriteData[7:0];
          `FRWLS_ADDR_DATA_HIGH: dataHighQ <= {2'b00, avsWriteData[5:0]};
          `FRWLS_ADDR_ADDR_LOW: addrLowQ <= avsWriteData[7:0];
          `FRWLS_ADDR_ADDR_HIGH: addrHighQ <= {1'b1, avsWriteData[6:0]};
          `FRWLS_ADDR_CONTROL: begin
            cfgQ <= avsWriteData[`FRWLS_BIT_CFG];
            latchOnlyQ <= avsWriteData[`FRWLS_BIT_LATCH_ONLY];
            eraseQ <= avsWriteData[`FRWLS_BIT_ERASE];
            enableQ <= avsWriteData[`FRWLS_BIT_ENABLE];
            if (startReq) begin
              errQ <= !accept;
              startQ <= accept && !cfgQ;
            end else if (!avsWriteData[`FRWLS_BIT_ERROR]) begin
              errQ <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // ****************************************
      // Sequencer outputs
      // ****************************************
      if (stateQ == ST_IDLE && stateD == ST_NOP) begin
        // Taken from the accepting write, as the latch load is, not the stored bits
        pendEraseQ <= avsWriteData[`FRWLS_BIT_ERASE];
        pendCommitQ <= !avsWriteData[`FRWLS_BIT_ERASE] &&
          !avsWriteData[`FRWLS_BIT_LATCH_ONLY];
        nopCntQ <= 2'd0;
        cpuForceNop <= 1'b1;
        flashRow <= {addrHighQ[6:0], addrLowQ[7:5]};
      end else if (stateQ == ST_NOP) begin
        nopCntQ <= nopCntQ + 2'd1;
        if (stateD != ST_NOP) begin
          cpuForceNop <= 1'b0;
          cpuStall <= (stateD != ST_DONE);
          waitCntQ <= PROG_CYCLES - 1;
          dumpIdxQ <= 5'h00;
          flashErase <= pendEraseQ;
        end
      end else if (stateQ == ST_PROG || stateQ == ST_ERASE) begin
        waitCntQ <= waitCntQ - 32'd1;
        // Latch words streamed out one per cycle; no erase here
        flashProgram <= (stateQ == ST_PROG) && (waitCntQ > PROG_CYCLES - 1 - `FRWLS_LATCHES);
        flashWordIdx <= dumpIdxQ;
        flashWordData <= latchOut;
        dumpIdxQ <= dumpIdxQ + 5'h01;
        if (stateD == ST_DONE) begin
          cpuStall <= 1'b0;
          flashErase <= 1'b0;
          flashProgram <= 1'b0;
        end
      end else if (stateQ == ST_DONE) begin
        startQ <= 1'b0;
        eraseQ <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/frwls_seq_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module frwls_seq_sva #(parameter int PROG_CYCLES = 64) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cpuForceNop,
  input wire logic cpuStall,
  input wire logic flashProgram,
  input wire logic flashErase,
  input wire logic [9:0] flashRow,
  input wire logic [4:0] flashWordIdx
);
  // ****
  // Run lengths, too long to unroll
  // ****
  int stCnt_q;
  int prCnt_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stCnt_q <= 0;
      prCnt_q <= 0;
    end else begin
      stCnt_q <= cpuStall ? stCnt_q + 1 : 0;
      prCnt_q <= flashProgram ? prCnt_q + 1 : 0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence nopPair;
    cpuForceNop [*2] ##1 !cpuForceNop;
  endsequence
  sequence streaming;
    flashProgram && $past(flashProgram);
  endsequence
  a_nop_pair: assert property ($rose(cpuForceNop) |-> nopPair)
    else $error("nop length");
  a_stall_cause: assert property ($rose(cpuStall) |-> $past(cpuForceNop, 2))
    else $error("stall without nops");
  a_stall_len: assert property ($fell(cpuStall) |-> stCnt_q == PROG_CYCLES)
    else $error("stall length");
  a_prog_len: assert property ($fell(flashProgram) |-> prCnt_q == 32)
    else $error("word count");
  a_prog_safe: assert property (flashProgram |-> cpuStall && !flashErase)
    else $error("program state");
  a_erase_stall: assert property (flashErase |-> cpuStall && !flashProgram)
    else $error("erase state");
  a_row_fixed: assert property (streaming |-> $stable(flashRow))
    else $error("row moved");
  a_idx_step: assert property (streaming |-> flashWordIdx == $past(flashWordIdx) + 5'h01)
    else $error("index step");
endmodule
bind frwls_sequencer frwls_seq_sva #(.PROG_CYCLES(PROG_CYCLES)) i_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .cpuForceNop(cpuForceNop), .cpuStall(cpuStall),
  .flashProgram(flashProgram), .flashErase(flashErase), .flashRow(flashRow),
  .flashWordIdx(flashWordIdx));
`default_nettype wire

// [tb/frwls_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module frwls_flash_model (
  input wire logic ref_clk,
  input wire logic flashProgram,
  input wire logic flashErase,
  input wire logic [9:0] flashRow,
  input wire logic [4:0] flashWordIdx,
  input wire logic [13:0] flashWordData
);
  // ****
  // Passive array, never stalls the writer
  // ****
  logic [13:0] img [32];
  logic [9:0] row;
  logic erD = 1'b0;
  int nErase = 0;
  always @(posedge ref_clk) begin
    erD <= flashErase;
    if (flashErase && !erD) nErase++;
    if (flashProgram) img[flashWordIdx] <= flashWordData;
    if (flashProgram) row <= flashRow;
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic [2:0] avsAddress = 3'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData;
  logic avsWaitRequest, cpuForceNop, cpuStall, flashProgram, flashErase, nopD, stD;
  logic [9:0] flashRow;
  logic [4:0] flashWordIdx;
  logic [13:0] flashWordData, w;
  logic [13:0] refImg [32];
  logic timedOut = 1'b0;
  logic [7:0] rd, ah, al;
  int n_mismatch = 0, checks_done = 0, nNop = 0, nSt = 0, k, nn, ns;
  frwls_sequencer #(.PROG_CYCLES(64)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .cpuForceNop(cpuForceNop), .cpuStall(cpuStall),
    .flashProgram(flashProgram), .flashErase(flashErase), .flashRow(flashRow),
    .flashWordIdx(flashWordIdx), .flashWordData(flashWordData));
  frwls_flash_model i_flash (
    .ref_clk(ref_clk), .flashProgram(flashProgram), .flashErase(flashErase),
    .flashRow(flashRow), .flashWordIdx(flashWordIdx), .flashWordData(flashWordData));
  initial forever #5 ref_clk = ~ref_clk;
  // ****
  // Pulse counters and bus tasks
  // ****
  always @(posedge ref_clk) begin
    nopD <= cpuForceNop;
    stD <= cpuStall;
    if (cpuForceNop && !nopD) nNop++;
    if (cpuStall && !stD) nSt++;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (timedOut) return;
    @(posedge ref_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {24'h0, d};
    // Held until the edge that samples waitrequest low; data taken there
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rd = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      timedOut = 1'b1;
      n_mismatch++;
      $display("wrong value at %0t: bus hang", $time);
    end
  endtask
  task automatic go(input logic [7:0] c);
    bus(1'b1, 3'h5, 8'h55);
    bus(1'b1, 3'h5, 8'hAA);
    bus(1'b1, 3'h4, c);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, 3'h6, 8'h00);
      n++;
    end while (rd !== 8'h01 && n < 300 && !timedOut);
    if (n >= 300) begin
      timedOut = 1'b1;
      n_mismatch++;
      $display("wrong value at %0t: busy hang", $time);
    end
  endtask
  task automatic load(input logic [7:0] a);
    w = 14'($urandom);
    bus(1'b1, 3'h2, a);
    bus(1'b1, 3'h0, w[7:0]);
    bus(1'b1, 3'h1, {2'b00, w[13:8]});
  endtask
  function automatic logic [9:0] rowOf(input logic [7:0] h, input logic [7:0] l);
    return {h[6:0], l[7:5]};
  endfunction
  initial begin
    void'($urandom(32'haa13));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, 3'h6, 8'h00);
    chk(32'(rd), 1, "idle status");
    bus(1'b0, 3'h7, 8'h00);
    chk(32'(rd), 0, "unmapped read");
    for (int p = 0; p < 2; p++) begin
      ah = 8'($urandom);
      al = 8'($urandom);
      k = 2 + $urandom % 4;
      foreach (refImg[j]) refImg[j] = 14'h3FFF;
      bus(1'b1, 3'h4, 8'h24);
      bus(1'b1, 3'h3, ah);
      if (p == 1) begin
        // Latch 0 loaded, then the row erase must blank it again
        al[4:0] = 5'h00;
        load(al);
        go(8'h26);
        idle;
        go(8'h16);
        idle;
        chk(i_flash.nErase, 1, "erase");
      end
      ns = nSt;
      al[4:0] = 5'($urandom % 26);
      for (int i = 0; i < k; i++) begin
        load(al);
        nn = nNop;
        go(8'h26);
        idle;
        chk(nNop - nn, 1, "nop pair");
        refImg[al[4:0]] = w;
        al = al + 8'h01;
      end
      chk(nSt - ns, 0, "stall on load");
      bus(1'b1, 3'h4, 8'h04);
      al[4:0] = 5'h1F;
      load(al);
      go(8'h06);
      idle;
      refImg[31] = w;
      chk(nSt - ns, 1, "commit stall");
      chk(i_flash.nErase, p, "no erase on write");
      bus(1'b0, 3'h4, 8'h00);
      chk(32'(rd[1]), 0, "start bit");
      chk(32'(i_flash.row), 32'(rowOf(ah, al)), "row");
      for (int i = 0; i < 32; i++) chk(32'(i_flash.img[i]), 32'(refImg[i]), "word");
      $display("row pass %0d done", p);
    end
    nn = nNop;
    bus(1'b1, 3'h4, 8'h24);
    bus(1'b1, 3'h5, 8'h55);
    bus(1'b1, 3'h0, 8'h12);
    bus(1'b1, 3'h5, 8'hAA);
    bus(1'b1, 3'h4, 8'h26);
    bus(1'b0, 3'h4, 8'h00);
    chk(32'(rd[3]), 1, "error flag");
    bus(1'b1, 3'h4, 8'h00);
    go(8'h22);
    bus(1'b0, 3'h4, 8'h00);
    chk(nNop - nn, 0, "refused start");
    $display("unlock tests done");
    print_verdict;
  end
endmodule
`default_nettype wire
